// ---- rtl/tmpreg_pkg.sv ----
// Package with register indices, field layouts and reset values of the temperature register bank.
package tmpreg_pkg;
    // Register indices; the APB byte address of each register is four times its index.
    localparam logic [7:0] IDX_LOCAL_TEMP     = 8'h00;
    localparam logic [7:0] IDX_REMOTE_UPPER   = 8'h01;
    localparam logic [7:0] IDX_LOCAL_HIGH     = 8'h05;
    localparam logic [7:0] IDX_RHIGH_UPPER    = 8'h07;
    localparam logic [7:0] IDX_RLOW_UPPER     = 8'h08;
    localparam logic [7:0] IDX_REMOTE_LOWER   = 8'h10;
    localparam logic [7:0] IDX_OFFSET_UPPER   = 8'h11;
    localparam logic [7:0] IDX_OFFSET_LOWER   = 8'h12;
    localparam logic [7:0] IDX_RHIGH_LOWER    = 8'h13;
    localparam logic [7:0] IDX_RLOW_LOWER     = 8'h14;
    localparam logic [7:0] IDX_IRQ_STATUS     = 8'h20;
    localparam logic [7:0] IDX_IRQ_ENABLE     = 8'h21;
    localparam logic [7:0] IDX_IRQ_CLEAR      = 8'h22;
    localparam logic [7:0] IDX_CONFIG         = 8'h23;

    localparam int         ADDR_W             = 10;
    localparam int         DATA_W             = 32;
    localparam int         TEMP_W             = 11;
    localparam int         FRAC_W             = 3;
    localparam int         FRAC_LSB           = 5;
    localparam int         NUM_EVENTS         = 4;

    // Event bit positions in the status, enable and clear registers.
    localparam int         EV_REMOTE_HIGH     = 0;
    localparam int         EV_REMOTE_LOW      = 1;
    localparam int         EV_LOCAL_HIGH      = 2;
    localparam int         EV_CONV_DONE       = 3;

    localparam int         CFG_FAULT_QUEUE    = 0;
    localparam logic [1:0] FAULT_QUEUE_DEPTH  = 2'h3;

    localparam logic [7:0] RST_LOCAL_HIGH     = 8'h46;
    localparam logic [7:0] RST_RHIGH_UPPER    = 8'h46;
    localparam logic [7:0] RST_RLOW_UPPER     = 8'h00;
    localparam logic [2:0] RST_FRAC           = 3'h0;
    localparam logic [7:0] RST_OFFSET_UPPER   = 8'h00;
    localparam logic [7:0] RST_TEMP           = 8'h00;
    localparam logic [3:0] RST_IRQ            = 4'h0;
endpackage

// ---- rtl/tmpreg_conv_if.sv ----
// Interface between the register bank and its conversion result path.
`timescale 1ns/1ps
interface tmpreg_conv_if;
    import tmpreg_pkg::*;
    logic                     raw_valid;
    logic        [7:0]        local_raw;
    logic signed [TEMP_W-1:0] remote_raw;
    logic signed [TEMP_W-1:0] offset;
    logic signed [TEMP_W-1:0] high_lim;
    logic signed [TEMP_W-1:0] low_lim;
    logic        [7:0]        local_lim;
    logic                     res_valid;
    logic        [7:0]        local_res;
    logic signed [TEMP_W-1:0] remote_res;
    logic                     over;
    logic                     under;
    logic                     local_over;

    modport regs (output raw_valid, local_raw, remote_raw, offset, high_lim, low_lim,
                  local_lim, input res_valid, local_res, remote_res, over, under, local_over);
    modport path (input raw_valid, local_raw, remote_raw, offset, high_lim, low_lim,
                  local_lim, output res_valid, local_res, remote_res, over, under, local_over);
endinterface

// ---- rtl/tmpreg_conv_path.sv ----
// Conversion result path: adds the offset, saturates and compares against the limits.
`timescale 1ns/1ps
module tmpreg_conv_path (
    input wire logic     pclk,
    input wire logic     presetn,
    tmpreg_conv_if.path  cv
);
    import tmpreg_pkg::*;

    localparam logic signed [TEMP_W:0] SUM_MAX = (TEMP_W+1)'(2**(TEMP_W-1) - 1);
    localparam logic signed [TEMP_W:0] SUM_MIN = -(TEMP_W+1)'(2**(TEMP_W-1));

    logic signed [TEMP_W:0]   sum_wide;
    logic signed [TEMP_W-1:0] sum_sat;

    // The sum is one bit wider so that an extreme offset clips instead of wrapping sign.
    always_comb begin
        sum_wide = (TEMP_W+1)'(cv.remote_raw) + (TEMP_W+1)'(cv.offset);
        if (sum_wide > SUM_MAX) begin
            sum_sat = SUM_MAX[TEMP_W-1:0];
        end else if (sum_wide < SUM_MIN) begin
            sum_sat = SUM_MIN[TEMP_W-1:0];
        end else begin
            sum_sat = sum_wide[TEMP_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cv.res_valid  <= 1'b0;
            cv.local_res  <= RST_TEMP;
            cv.remote_res <= '0;
            cv.over       <= 1'b0;
            cv.under      <= 1'b0;
            cv.local_over <= 1'b0;
        end else begin
            cv.res_valid <= cv.raw_valid;
            if (cv.raw_valid) begin
                cv.local_res  <= cv.local_raw;
                cv.remote_res <= sum_sat;
                cv.over       <= sum_sat > cv.high_lim;
                cv.under      <= sum_sat < cv.low_lim;
                cv.local_over <= $signed(cv.local_raw) > $signed(cv.local_lim);
            end
        end
    end
endmodule

// ---- rtl/tmpreg_regs.sv ----
// Temperature result and limit register bank with APB slave and interrupt logic.
`timescale 1ns/1ps
module tmpreg_regs (
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire logic [tmpreg_pkg::ADDR_W-1:0]         paddr,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [tmpreg_pkg::DATA_W-1:0]         pwdata,
    output logic      [tmpreg_pkg::DATA_W-1:0]         prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    input  wire logic                                  conv_done,
    input  wire logic [7:0]                            local_raw,
    input  wire logic signed [tmpreg_pkg::TEMP_W-1:0]  remote_raw,
    output logic                                       irq
);
    import tmpreg_pkg::*;

    tmpreg_conv_if cv ();

    logic [7:0]            local_temp_reg;
    logic [7:0]            remote_upper_reg;
    logic [2:0]            remote_lower_reg;
    logic [7:0]            local_high_reg;
    logic [7:0]            rhigh_upper_reg;
    logic [2:0]            rhigh_lower_reg;
    logic [7:0]            rlow_upper_reg;
    logic [2:0]            rlow_lower_reg;
    logic [7:0]            offset_upper_reg;
    logic [2:0]            offset_lower_reg;
    logic [NUM_EVENTS-1:0] status_reg;
    logic [NUM_EVENTS-1:0] enable_reg;
    logic                  fault_queue_reg;
    logic [1:0]            fault_cnt_reg;
    logic [1:0]            fault_cnt_next;
    logic [NUM_EVENTS-1:0] event_set;
    logic [NUM_EVENTS-1:0] event_clr;
    logic [7:0]            idx;
    logic                  mapped;
    logic                  wr_en;
    logic [7:0]            wbyte;
    logic [7:0]            rd_byte;
    logic                  remote_alert;

    assign idx   = paddr[ADDR_W-1:2];
    assign wbyte = pwdata[7:0];
    assign wr_en = psel && penable && pwrite && mapped;

    // Reads are captured in the setup phase so the access phase never needs a wait state.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        mapped  = 1'b1;
        rd_byte = 8'h00;
        if (paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end else if (idx == IDX_LOCAL_TEMP) begin
            rd_byte = local_temp_reg;
        end else if (idx == IDX_REMOTE_UPPER) begin
            rd_byte = remote_upper_reg;
        end else if (idx == IDX_LOCAL_HIGH) begin
            rd_byte = local_high_reg;
        end else if (idx == IDX_RHIGH_UPPER) begin
            rd_byte = rhigh_upper_reg;
        end else if (idx == IDX_RLOW_UPPER) begin
            rd_byte = rlow_upper_reg;
        end else if (idx == IDX_REMOTE_LOWER) begin
            rd_byte = {remote_lower_reg, 5'h00};
        end else if (idx == IDX_OFFSET_UPPER) begin
            rd_byte = offset_upper_reg;
        end else if (idx == IDX_OFFSET_LOWER) begin
            rd_byte = {offset_lower_reg, 5'h00};
        end else if (idx == IDX_RHIGH_LOWER) begin
            rd_byte = {rhigh_lower_reg, 5'h00};
        end else if (idx == IDX_RLOW_LOWER) begin
            rd_byte = {rlow_lower_reg, 5'h00};
        end else if (idx == IDX_IRQ_STATUS) begin
            rd_byte = {4'h0, status_reg};
        end else if (idx == IDX_IRQ_ENABLE) begin
            rd_byte = {4'h0, enable_reg};
        end else if (idx == IDX_IRQ_CLEAR) begin
            rd_byte = 8'h00;
        end else if (idx == IDX_CONFIG) begin
            rd_byte = {7'h00, fault_queue_reg};
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h000000, rd_byte};
        end
    end

    // Limits, offset and configuration written by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            local_high_reg   <= RST_LOCAL_HIGH;
            rhigh_upper_reg  <= RST_RHIGH_UPPER;
            rhigh_lower_reg  <= RST_FRAC;
            rlow_upper_reg   <= RST_RLOW_UPPER;
            rlow_lower_reg   <= RST_FRAC;
            offset_upper_reg <= RST_OFFSET_UPPER;
            offset_lower_reg <= RST_FRAC;
            enable_reg       <= RST_IRQ;
            fault_queue_reg  <= 1'b0;
        end else if (wr_en) begin
            if (idx == IDX_LOCAL_HIGH) begin
                local_high_reg <= wbyte;
            end else if (idx == IDX_RHIGH_UPPER) begin
                rhigh_upper_reg <= wbyte;
            end else if (idx == IDX_RHIGH_LOWER) begin
                rhigh_lower_reg <= wbyte[7:FRAC_LSB];
            end else if (idx == IDX_RLOW_UPPER) begin
                rlow_upper_reg <= wbyte;
            end else if (idx == IDX_RLOW_LOWER) begin
                rlow_lower_reg <= wbyte[7:FRAC_LSB];
            end else if (idx == IDX_OFFSET_UPPER) begin
                offset_upper_reg <= wbyte;
            end else if (idx == IDX_OFFSET_LOWER) begin
                offset_lower_reg <= wbyte[7:FRAC_LSB];
            end else if (idx == IDX_IRQ_ENABLE) begin
                enable_reg <= wbyte[NUM_EVENTS-1:0];
            end else if (idx == IDX_CONFIG) begin
                fault_queue_reg <= wbyte[CFG_FAULT_QUEUE];
            end
        end
    end

    assign cv.raw_valid  = conv_done;
    assign cv.local_raw  = local_raw;
    assign cv.remote_raw = remote_raw;
    assign cv.offset     = {offset_upper_reg, offset_lower_reg};
    assign cv.high_lim   = {rhigh_upper_reg, rhigh_lower_reg};
    assign cv.low_lim    = {rlow_upper_reg, rlow_lower_reg};
    assign cv.local_lim  = local_high_reg;

    tmpreg_conv_path u_path (
        .pclk    (pclk),
        .presetn (presetn),
        .cv      (cv)
    );

    // Readings are only ever loaded from the result path, so bus writes cannot reach them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            local_temp_reg   <= RST_TEMP;
            remote_upper_reg <= RST_TEMP;
            remote_lower_reg <= RST_FRAC;
        end else if (cv.res_valid) begin
            local_temp_reg   <= cv.local_res;
            remote_upper_reg <= cv.remote_res[TEMP_W-1:FRAC_W];
            remote_lower_reg <= cv.remote_res[FRAC_W-1:0];
        end
    end

    // With the queue on, three consecutive out-of-range results are needed for an alert.
    always_comb begin
        fault_cnt_next = fault_cnt_reg;
        if (cv.res_valid) begin
            if (!(cv.over || cv.under)) begin
                fault_cnt_next = 2'h0;
            end else if (fault_cnt_reg != FAULT_QUEUE_DEPTH) begin
                fault_cnt_next = fault_cnt_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_cnt_reg <= 2'h0;
        end else begin
            fault_cnt_reg <= fault_cnt_next;
        end
    end

    assign remote_alert = cv.res_valid && (cv.over || cv.under) &&
                          (!fault_queue_reg || fault_cnt_next == FAULT_QUEUE_DEPTH);

    always_comb begin
        event_set                 = '0;
        event_set[EV_REMOTE_HIGH] = remote_alert && cv.over;
        event_set[EV_REMOTE_LOW]  = remote_alert && cv.under;
        event_set[EV_LOCAL_HIGH]  = cv.res_valid && cv.local_over;
        event_set[EV_CONV_DONE]   = cv.res_valid;
    end

    assign event_clr = (wr_en && idx == IDX_IRQ_CLEAR) ? wbyte[NUM_EVENTS-1:0] : '0;

    // A new event in the same cycle as its clear keeps the bit set.
    generate
        for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_status
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    status_reg[i] <= 1'b0;
                end else if (event_set[i]) begin
                    status_reg[i] <= 1'b1;
                end else if (event_clr[i]) begin
                    status_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign irq = |(status_reg & enable_reg);

    // Checking helpers.
    logic                     lhl_written_reg;
    logic                     rhl_written_reg;
    logic signed [TEMP_W:0]   exp_sum;

    assign exp_sum = (TEMP_W+1)'(remote_raw) + (TEMP_W+1)'(cv.offset);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lhl_written_reg <= 1'b0;
            rhl_written_reg <= 1'b0;
        end else if (wr_en) begin
            if (idx == IDX_LOCAL_HIGH) begin
                lhl_written_reg <= 1'b1;
            end
            if (idx == IDX_RHIGH_UPPER || idx == IDX_RHIGH_LOWER) begin
                rhl_written_reg <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_local_ro;
        wr_en && idx == IDX_LOCAL_TEMP && !cv.res_valid |=> $stable(local_temp_reg);
    endproperty
    a_local_ro: assert property (p_local_ro) else $error("Local reading changed by a write.");

    property p_local_follows;
        conv_done |-> ##2 local_temp_reg == $past(local_raw, 2);
    endproperty
    a_local_follows: assert property (p_local_follows) else $error("Local reading not refreshed.");

    property p_lhl_reset;
        !lhl_written_reg |-> local_high_reg == 8'h46;
    endproperty
    a_lhl_reset: assert property (p_lhl_reset) else $error("Local high limit lost reset value.");

    property p_remote_sum;
        conv_done && exp_sum[TEMP_W] == exp_sum[TEMP_W-1] && $stable(cv.offset)
            |-> ##2 {remote_upper_reg, remote_lower_reg} == $past(exp_sum[TEMP_W-1:0], 2);
    endproperty
    a_remote_sum: assert property (p_remote_sum) else $error("Remote reading is not raw plus offset.");

    property p_upper_sign;
        cv.res_valid |=> remote_upper_reg[7] == $past(cv.remote_res[TEMP_W-1]);
    endproperty
    a_upper_sign: assert property (p_upper_sign) else $error("Remote sign bit misplaced.");

    property p_lower_zero;
        psel && !penable && !pwrite && idx == IDX_REMOTE_LOWER |=> prdata[4:0] == 5'h00;
    endproperty
    a_lower_zero: assert property (p_lower_zero) else $error("Remote lower low bits not zero.");

    property p_rhl_reset;
        !rhl_written_reg |-> rhigh_upper_reg == 8'h46 && rhigh_lower_reg == 3'h0;
    endproperty
    a_rhl_reset: assert property (p_rhl_reset) else $error("Remote high limit lost reset value.");

    property p_alert_noqueue;
        cv.res_valid && !fault_queue_reg && cv.over |=> status_reg[EV_REMOTE_HIGH];
    endproperty
    a_alert_noqueue: assert property (p_alert_noqueue) else $error("Remote high alert not flagged.");

    property p_irq_high;
        status_reg[EV_REMOTE_HIGH] && enable_reg[EV_REMOTE_HIGH] |-> irq;
    endproperty
    a_irq_high: assert property (p_irq_high) else $error("Enabled alert does not raise irq.");

    property p_irq_masked;
        enable_reg == RST_IRQ |-> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("Irq high with all sources masked.");

    property p_alert_low;
        cv.res_valid && !fault_queue_reg && cv.under |=> status_reg[EV_REMOTE_LOW];
    endproperty
    a_alert_low: assert property (p_alert_low) else $error("Remote low alert not flagged.");

    property p_bytes_together;
        $changed(remote_upper_reg) || $changed(remote_lower_reg) |-> $past(cv.res_valid);
    endproperty
    a_bytes_together: assert property (p_bytes_together) else $error("Reading changed mid-conversion.");

    c_conv: cover property (conv_done ##2 cv.res_valid == 1'b0);
    c_irq: cover property ($rose(irq));
    c_queue: cover property (fault_queue_reg && remote_alert);
    c_unmapped: cover property (pslverr);
endmodule

// ---- dv/tmpreg_host_model.sv ----
// Host model that reaches the register bank as an APB master.
`timescale 1ns/1ps
module tmpreg_host_model (
    input  wire logic                            pclk,
    output logic      [tmpreg_pkg::ADDR_W-1:0]   paddr,
    output logic                                 psel,
    output logic                                 penable,
    output logic                                 pwrite,
    output logic      [tmpreg_pkg::DATA_W-1:0]   pwdata,
    input  wire logic [tmpreg_pkg::DATA_W-1:0]   prdata,
    input  wire logic                            pready,
    input  wire logic                            pslverr
);
    import tmpreg_pkg::*;
    logic timed_out;

    initial begin
        paddr     = '0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        pwdata    = '0;
        timed_out = 1'b0;
    end

    // One whole transfer; the request stands until pready is seen high at an edge, or until 21 access-phase edges have passed.
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        forever begin
            @(posedge pclk);
            n++;
            if (pready === 1'b1 || n > 20) begin
                break;
            end
        end
        if (n > 20) begin
            timed_out = 1'b1;
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released bus carries a changed pattern rather than stale data.
        pwdata  <= ~wd;
    endtask

    // Upper byte is fetched before the lower one; nothing latches the lower byte, so a result landing between the two reads mixes two results.
    task automatic read_remote(output logic [7:0] up, output logic [7:0] lo);
        logic [31:0] d;
        logic        e;
        xfer(1'b0, IDX_REMOTE_UPPER, 32'h0, d, e);
        up = d[7:0];
        xfer(1'b0, IDX_REMOTE_LOWER, 32'h0, d, e);
        lo = d[7:0];
    endtask
endmodule

// ---- dv/temp_result_limit_regs_bench.sv ----
// Self-checking testbench of the temperature register bank.
`timescale 1ns/1ps
module temp_result_limit_regs_bench;
    import tmpreg_pkg::*;
    logic                     pclk = 1'b0;
    logic                     presetn = 1'b0;
    logic [ADDR_W-1:0]        paddr;
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [DATA_W-1:0]        pwdata;
    logic [DATA_W-1:0]        prdata;
    logic                     pready;
    logic                     pslverr;
    logic                     conv_done = 1'b0;
    logic [7:0]               local_raw = 8'h00;
    logic signed [TEMP_W-1:0] remote_raw = '0;
    logic                     irq;
    int                       err_total = 0;
    int                       samples_checked = 0;

    tmpreg_regs dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
        .local_raw(local_raw), .remote_raw(remote_raw), .irq(irq));
    tmpreg_host_model host_u (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial begin
        forever #20 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] d;
        logic        e;
        host_u.xfer(1'b1, idx, {24'h0, v}, d, e);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        logic        e;
        host_u.xfer(1'b0, idx, 32'h0, d, e);
        chk(d, {24'h0, exp});
        chk({31'h0, e}, 32'h0);
    endtask

    // The note fixes the result two edges after the pulse; a third edge gives margin.
    task automatic conv(input logic [7:0] loc, input logic [10:0] rem);
        @(posedge pclk);
        conv_done  <= 1'b1;
        local_raw  <= loc;
        remote_raw <= rem;
        @(posedge pclk);
        conv_done  <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic remote_chk(input logic [10:0] v);
        logic [7:0] up;
        logic [7:0] lo;
        host_u.read_remote(up, lo);
        chk({24'h0, up}, {24'h0, v[10:3]});
        chk({24'h0, lo}, {24'h0, v[2:0], 5'h00});
    endtask

    task automatic sc_reset_values();
        rd_chk(IDX_LOCAL_HIGH, 8'h46);
        rd_chk(IDX_RHIGH_UPPER, 8'h46);
        rd_chk(IDX_RHIGH_LOWER, 8'h00);
        rd_chk(IDX_OFFSET_LOWER, 8'h00);
    endtask

    task automatic sc_readings();
        conv(8'h19, 11'h5a3);
        rd_chk(IDX_LOCAL_TEMP, 8'h19);
        wr(IDX_LOCAL_TEMP, 8'hff);
        rd_chk(IDX_LOCAL_TEMP, 8'h19);
        remote_chk(11'h5a3);
        wr(IDX_RHIGH_LOWER, 8'hff);
        rd_chk(IDX_RHIGH_LOWER, 8'he0);
        wr(IDX_RHIGH_LOWER, 8'h00);
    endtask

    task automatic sc_offset();
        wr(IDX_OFFSET_UPPER, 8'h02);
        wr(IDX_OFFSET_LOWER, 8'hbf);
        rd_chk(IDX_OFFSET_LOWER, 8'ha0);
        conv(8'h19, 11'h100);
        remote_chk(11'h115);
        wr(IDX_OFFSET_UPPER, 8'hff);
        wr(IDX_OFFSET_LOWER, 8'h00);
        conv(8'h19, 11'h100);
        remote_chk(11'h0f8);
        wr(IDX_OFFSET_UPPER, 8'h00);
    endtask

    task automatic sc_alert();
        logic [31:0] d;
        logic        e;
        wr(IDX_RHIGH_UPPER, 8'h10);
        conv(8'h19, 11'h100);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd_chk(IDX_IRQ_STATUS, 8'h0b);
        wr(IDX_IRQ_ENABLE, 8'h01);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr(IDX_IRQ_CLEAR, 8'h01);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd_chk(IDX_IRQ_CLEAR, 8'h00);
        conv(8'h50, 11'h7f8);
        rd_chk(IDX_IRQ_STATUS, 8'h0e);
        host_u.xfer(1'b0, 8'hff, 32'h0, d, e);
        chk(d, 32'h0);
        chk({31'h0, e}, 32'h1);
    endtask

    // An in-range result first empties the queue counter left over from earlier scenarios.
    task automatic sc_fault_queue();
        wr(IDX_CONFIG, 8'h01);
        conv(8'h19, 11'h008);
        wr(IDX_IRQ_CLEAR, 8'h0f);
        conv(8'h19, 11'h100);
        conv(8'h19, 11'h100);
        rd_chk(IDX_IRQ_STATUS, 8'h08);
        conv(8'h19, 11'h100);
        rd_chk(IDX_IRQ_STATUS, 8'h09);
        wr(IDX_CONFIG, 8'h00);
    endtask

    task automatic complete_run();
        if (host_u.timed_out === 1'b1) begin
            err_total++;
        end
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        sc_reset_values();
        sc_readings();
        sc_offset();
        sc_alert();
        sc_fault_queue();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        complete_run();
    end
endmodule
